// File: acp_regs.sv
`timescale 1ns/1ps
// Operation
// - power-down mask resets to zero, all powered
// - set bit powers channel off, drops it from scan
// - clear bit keeps channel powered and scannable
// - all bits set: everything off, output invalid
// - absent-channel bit writes change nothing
// - absent-channel bits read back as ones
// - top two bits hold chain position id
// - bits five and three are zero
// - bit four enables threshold alarm, reset zero
// - low three bits pick output format
// - formats append channel, device, then range
// - channel address is four bits, binary
// - device address two bits, chain id
module acp_regs #(
   parameter int NUM_CH = 8
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register access from serial framing
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [6:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rvalid,
   // configuration to front ends, scan, alarm
   output logic      [7:0]  chan_power_on,
   output logic      [7:0]  scan_allowed,
   output logic             all_powered_off,
   output logic             alarm_enable,
   output logic      [1:0]  chain_position_id,
   output logic      [2:0]  output_word_format,
   // conversion in
   input  wire logic        conv_valid,
   input  wire logic [15:0] conv_result,
   input  wire logic [2:0]  conv_channel,
   input  wire logic [2:0]  conv_range,
   input  wire logic        fixed_channel_mode,
   // formatted word out
   output logic             out_valid,
   output logic      [24:0] out_word,
   output logic      [4:0]  out_bits,
   output logic             out_invalid
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  pd;
      logic [1:0]  chain_id;
      logic        alarm;
      logic [2:0]  fmt;
      logic [7:0]  rdata;
      logic        rvalid;
      logic [7:0]  pwr_on;
      logic [7:0]  scan_ok;
      logic        all_off;
      logic        ovalid;
      logic [24:0] word;
      logic [4:0]  nbits;
      logic        oinvalid;
   } acp_state_t;

   localparam logic [7:0] PRESENT =
      (NUM_CH == 4) ? acp_pkg::PRESENT_4CH : acp_pkg::PRESENT_8CH;

   acp_state_t  st;
   acp_state_t  next_st;
   logic [7:0]  chan_on;
   logic        every_off;
   logic [7:0]  feat_rd;
   logic [24:0] fmt_word;
   logic [4:0]  fmt_bits;

   // ------------------------------------------------------------
   // per-channel enables
   // ------------------------------------------------------------
   // absent channels never report as powered or scannable
   for (genvar i = 0; i < 8; i++) begin : g_chan
      assign chan_on[i] = PRESENT[i] & ~st.pd[i];
   end

   // absent bits count as off so a full mask on the small part still trips
   assign every_off = &(st.pd | ~PRESENT);

   assign feat_rd = {st.chain_id, 1'b0, st.alarm, 1'b0, st.fmt};

   // ------------------------------------------------------------
   // output word composer
   // ------------------------------------------------------------
   acp_word_fmt u_fmt (
      .format     (st.fmt),
      .chain_id   (st.chain_id),
      .result     (conv_result),
      .channel    (conv_channel),
      .range_code (conv_range),
      .word       (fmt_word),
      .nbits      (fmt_bits)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      next_st.ovalid = 1'b0;
      if (reg_wr) begin
         case (reg_addr)
            acp_pkg::POWER_MASK_ADDR: begin
               next_st.pd = reg_wdata & PRESENT;
            end
            acp_pkg::FEATURE_SEL_ADDR: begin
               next_st.chain_id = reg_wdata[acp_pkg::CHAIN_ID_MSB:acp_pkg::CHAIN_ID_LSB];
               next_st.alarm    = reg_wdata[acp_pkg::ALARM_EN_BIT];
               next_st.fmt      = reg_wdata[acp_pkg::FORMAT_MSB:acp_pkg::FORMAT_LSB];
            end
            default: begin
               next_st.pd = st.pd;
            end
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            acp_pkg::POWER_MASK_ADDR: begin
               next_st.rdata  = st.pd | ~PRESENT;
               next_st.rvalid = 1'b1;
            end
            acp_pkg::FEATURE_SEL_ADDR: begin
               next_st.rdata  = feat_rd;
               next_st.rvalid = 1'b1;
            end
            // other addresses belong to neighbouring register blocks
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end
      next_st.pwr_on  = chan_on;
      next_st.scan_ok = chan_on;
      next_st.all_off = every_off;
      if (conv_valid) begin
         next_st.ovalid   = 1'b1;
         next_st.word     = fmt_word;
         next_st.nbits    = fmt_bits;
         // flagged so alarm logic can discard a dead-channel result
         next_st.oinvalid = every_off | ~chan_on[conv_channel];
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         st          <= '0;
         st.pd       <= acp_pkg::POWER_MASK_RESET;
         st.chain_id <= acp_pkg::FEATURE_SEL_RESET[acp_pkg::CHAIN_ID_MSB:acp_pkg::CHAIN_ID_LSB];
         st.alarm    <= acp_pkg::FEATURE_SEL_RESET[acp_pkg::ALARM_EN_BIT];
         st.fmt      <= acp_pkg::FEATURE_SEL_RESET[acp_pkg::FORMAT_MSB:acp_pkg::FORMAT_LSB];
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata          = st.rdata;
   assign reg_rvalid         = st.rvalid;
   assign chan_power_on      = st.pwr_on;
   assign scan_allowed       = st.scan_ok;
   assign all_powered_off    = st.all_off;
   assign alarm_enable       = st.alarm;
   assign chain_position_id  = st.chain_id;
   assign output_word_format = st.fmt;
   assign out_valid          = st.ovalid;
   assign out_word           = st.word;
   assign out_bits           = st.nbits;
   assign out_invalid        = st.oinvalid;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // the power copy is registered, so it shows the reset mask one edge after release
   a_reset_powered: assert property ($fell(rst) |=> chan_power_on == PRESENT)
      else $error("channels not powered after reset");
   a_pd_bit_off: assert property (
      reg_wr && reg_addr == acp_pkg::POWER_MASK_ADDR ##1 !(reg_wr) |=>
      (chan_power_on & $past(reg_wdata, 2) & PRESENT) == 8'h00)
      else $error("powered-down channel still on");
   a_pd_bit_on: assert property (
      reg_wr && reg_addr == acp_pkg::POWER_MASK_ADDR ##1 !(reg_wr) |=>
      scan_allowed == (~$past(reg_wdata, 2) & PRESENT))
      else $error("cleared channel not scannable");
   // the all-off level lags a mask write, so a write just before is excluded
   a_all_off: assert property (
      conv_valid && all_powered_off && !reg_wr && !$past(reg_wr) |=>
      out_valid && out_invalid)
      else $error("all-off result not flagged invalid");
   a_absent_write: assert property (
      reg_wr && reg_addr == acp_pkg::POWER_MASK_ADDR |=> ##1
      (chan_power_on & ~PRESENT) == 8'h00)
      else $error("absent channel became active");
   a_absent_read: assert property (
      reg_rd && reg_addr == acp_pkg::POWER_MASK_ADDR |=>
      reg_rvalid && (reg_rdata & ~PRESENT) == ~PRESENT)
      else $error("absent channel bits not read as ones");
   a_feature_write: assert property (
      reg_wr && reg_addr == acp_pkg::FEATURE_SEL_ADDR |=>
      chain_position_id == $past(reg_wdata[7:6]) && alarm_enable == $past(reg_wdata[4])
      && output_word_format == $past(reg_wdata[2:0]))
      else $error("feature fields not taken from write");
   a_feature_hold: assert property (
      !(reg_wr && reg_addr == acp_pkg::FEATURE_SEL_ADDR) |=>
      $stable({chain_position_id, alarm_enable, output_word_format}))
      else $error("feature fields changed without a write");
   a_zero_bits: assert property (
      reg_rvalid && $past(reg_addr) == acp_pkg::FEATURE_SEL_ADDR |->
      reg_rdata[5] == 1'b0 && reg_rdata[3] == 1'b0)
      else $error("read-only zero bits read nonzero");
   a_rvalid_mapped: assert property (
      !(reg_rd && (reg_addr == acp_pkg::POWER_MASK_ADDR
      || reg_addr == acp_pkg::FEATURE_SEL_ADDR)) |=> !reg_rvalid)
      else $error("read answered for foreign address");
   a_scan_tracks: assert property (scan_allowed == chan_power_on)
      else $error("scan permission differs from power state");
   a_out_follows: assert property (conv_valid |=> out_valid)
      else $error("conversion not followed by output word");
   a_word_result: assert property (
      conv_valid |=> out_word[24:9] == $past(conv_result))
      else $error("result not at top of word");
   a_word_plain: assert property (
      conv_valid && output_word_format == acp_pkg::FMT_RESULT && !reg_wr |=>
      out_word[8:0] == 9'h000 && out_bits == acp_pkg::BITS_RESULT)
      else $error("plain format carries extra bits");
   a_word_chan: assert property (
      conv_valid && output_word_format != acp_pkg::FMT_RESULT
      && output_word_format[2] == 1'b0 && !reg_wr |=>
      out_word[8:5] == {1'b0, $past(conv_channel)})
      else $error("channel address missing from word");
   a_word_dev: assert property (
      conv_valid && output_word_format == acp_pkg::FMT_CHAN_DEV_RG && !reg_wr |=>
      out_word[4:3] == chain_position_id && out_bits == acp_pkg::BITS_FULL)
      else $error("device address missing from word");

   c_all_off: cover property (reg_wr && reg_addr == acp_pkg::POWER_MASK_ADDR
      && reg_wdata == acp_pkg::ALL_CHANNELS_OFF);
   c_full_word: cover property (out_valid && out_bits == acp_pkg::BITS_FULL);
   c_chan_word: cover property (out_valid && out_bits == acp_pkg::BITS_CHAN);
   c_single_dead: cover property (out_valid && out_invalid && !all_powered_off);
   c_fixed_dead: cover property (conv_valid && fixed_channel_mode
      && !chan_power_on[conv_channel]);

endmodule // acp_regs

// File: acp_pkg.sv
package acp_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [6:0] POWER_MASK_ADDR   = 7'h02;
   localparam logic [6:0] FEATURE_SEL_ADDR  = 7'h03;
   localparam logic [7:0] POWER_MASK_RESET  = 8'h00;
   localparam logic [7:0] FEATURE_SEL_RESET = 8'h00;
   localparam logic [7:0] ALL_CHANNELS_OFF  = 8'hFF;

   // ------------------------------------------------------------
   // feature select fields
   // ------------------------------------------------------------
   localparam int CHAIN_ID_MSB   = 7;
   localparam int CHAIN_ID_LSB   = 6;
   localparam int ZERO_BIT_HI    = 5;
   localparam int ALARM_EN_BIT   = 4;
   localparam int ZERO_BIT_LO    = 3;
   localparam int FORMAT_MSB     = 2;
   localparam int FORMAT_LSB     = 0;

   // ------------------------------------------------------------
   // channel variants
   // ------------------------------------------------------------
   localparam logic [7:0] PRESENT_8CH = 8'hFF;
   localparam logic [7:0] PRESENT_4CH = 8'h0F;

   // ------------------------------------------------------------
   // output word formats and layout
   // ------------------------------------------------------------
   localparam logic [2:0] FMT_RESULT      = 3'h0;
   localparam logic [2:0] FMT_CHAN        = 3'h1;
   localparam logic [2:0] FMT_CHAN_DEV    = 3'h2;
   localparam logic [2:0] FMT_CHAN_DEV_RG = 3'h3;
   localparam int         WORD_W          = 25;
   localparam int         RESULT_LSB      = 9;
   localparam int         CHAN_LSB        = 5;
   localparam int         DEVID_LSB       = 3;
   localparam logic [4:0] BITS_RESULT     = 5'h10;
   localparam logic [4:0] BITS_CHAN       = 5'h14;
   localparam logic [4:0] BITS_CHAN_DEV   = 5'h16;
   localparam logic [4:0] BITS_FULL       = 5'h19;

endpackage

// File: acp_word_fmt.sv
`timescale 1ns/1ps
module acp_word_fmt (
   // selection
   input  wire logic [2:0]  format,
   input  wire logic [1:0]  chain_id,
   // conversion
   input  wire logic [15:0] result,
   input  wire logic [2:0]  channel,
   input  wire logic [2:0]  range_code,
   // composed word
   output logic      [24:0] word,
   output logic      [4:0]  nbits
);

   // ------------------------------------------------------------
   // composer
   // ------------------------------------------------------------
   // unused bits stay low, as the pin is pulled low after the payload
   always_comb begin
      word = '0;
      word[acp_pkg::RESULT_LSB +: 16] = result;
      nbits = acp_pkg::BITS_RESULT;
      case (format)
         acp_pkg::FMT_CHAN: begin
            word[acp_pkg::CHAN_LSB +: 4] = {1'b0, channel};
            nbits = acp_pkg::BITS_CHAN;
         end
         acp_pkg::FMT_CHAN_DEV: begin
            word[acp_pkg::CHAN_LSB +: 4]  = {1'b0, channel};
            word[acp_pkg::DEVID_LSB +: 2] = chain_id;
            nbits = acp_pkg::BITS_CHAN_DEV;
         end
         acp_pkg::FMT_CHAN_DEV_RG: begin
            word[acp_pkg::CHAN_LSB +: 4]  = {1'b0, channel};
            word[acp_pkg::DEVID_LSB +: 2] = chain_id;
            word[2:0] = range_code;
            nbits = acp_pkg::BITS_FULL;
         end
         // undefined codes fall back to the bare result
         default: begin
            nbits = acp_pkg::BITS_RESULT;
         end
      endcase
   end

endmodule // acp_word_fmt

// File: acp_host.sv
`timescale 1ns/1ps
module acp_host (
   // clock
   input  wire logic       clk,
   // register access
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [6:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 7'h00;
      reg_wdata = 8'h00;
   end
   // no masking of data here, so the bench can provoke refusals
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // bounded wait: unmapped reads never answer
   task automatic rd(input logic [6:0] a, output logic ok, output logic [7:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      ok = 1'b0;
      for (int i = 0; i < 4 && !ok; i++) begin
         @(posedge clk);
         ok = reg_rvalid;
      end
      d = reg_rdata;
   endtask
endmodule // acp_host

// File: acp_regs_test.sv
`timescale 1ns/1ps
module acp_regs_test;
   typedef struct packed {logic [6:0] a; logic [7:0] d, e8, e4;} acp_row_t;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        reg_wr, reg_rd, rvalid, ok, seen, conv_valid, ov, all_off, all_off4;
   logic        alarm, inval, inval4;
   logic [6:0]  reg_addr;
   logic [7:0]  reg_wdata, rdata, rdata4, rd8, pwr, pwr4, scan;
   logic [15:0] conv_result = 16'hA5C3;
   logic [2:0]  conv_channel, fmt;
   logic [2:0]  conv_range = 3'h3;
   logic [1:0]  chain;
   logic [24:0] word;
   logic [4:0]  nbits;
   int          n_fail = 0;
   int          samples_checked = 0;
   acp_row_t rows [10] = '{'{7'h02, 8'h05, 8'h05, 8'hF5}, '{7'h02, 8'hF0, 8'hF0, 8'hF0},
      '{7'h02, 8'hFF, 8'hFF, 8'hFF}, '{7'h02, 8'h00, 8'h00, 8'hF0},
      '{7'h03, 8'hFF, 8'hD7, 8'hD7}, '{7'h03, 8'hC0, 8'hC0, 8'hC0},
      '{7'h03, 8'h13, 8'h13, 8'h13}, '{7'h03, 8'h46, 8'h46, 8'h46},
      '{7'h03, 8'h82, 8'h82, 8'h82}, '{7'h03, 8'h00, 8'h00, 8'h00}};
   logic [24:0] keep [4] = '{25'h1FFFE00, 25'h1FFFFE0, 25'h1FFFFF8, 25'h1FFFFFF};
   logic [4:0]  nb [4] = '{5'h10, 5'h14, 5'h16, 5'h19};

   always #2.5 clk = ~clk;

   acp_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rvalid(rvalid));
   // fixed channel mode never selected: a powered-down pick gives junk
   acp_regs uut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .chan_power_on(pwr),
      .scan_allowed(scan), .all_powered_off(all_off), .alarm_enable(alarm),
      .chain_position_id(chain), .output_word_format(fmt), .conv_valid(conv_valid),
      .conv_result(conv_result), .conv_channel(conv_channel), .conv_range(conv_range),
      .fixed_channel_mode(1'b0), .out_valid(ov), .out_word(word), .out_bits(nbits),
      .out_invalid(inval));
   acp_regs #(.NUM_CH(4)) uut4 (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata4), .reg_rvalid(),
      .chan_power_on(pwr4), .scan_allowed(), .all_powered_off(all_off4), .alarm_enable(),
      .chain_position_id(), .output_word_format(), .conv_valid(conv_valid),
      .conv_result(conv_result), .conv_channel(conv_channel), .conv_range(conv_range),
      .fixed_channel_mode(1'b0), .out_valid(), .out_word(), .out_bits(), .out_invalid(inval4));

   task automatic chk(input string n, input logic [24:0] e, input logic [24:0] s);
      samples_checked++;
      if (s !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, s);
         n_fail++;
      end
   endtask

   task automatic finish_test;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic do_conv(input logic [2:0] ch);
      @(posedge clk);
      conv_valid   <= 1'b1;
      conv_channel <= ch;
      @(posedge clk);
      conv_valid <= 1'b0;
      seen = 1'b0;
      for (int i = 0; i < 4 && !seen; i++) begin
         @(posedge clk);
         seen = ov;
      end
      chk("out_valid", 25'h1, {24'h0, seen});
   endtask

   initial begin
      conv_valid   = 1'b0;
      conv_channel = 3'h0;
      for (int r = 0; r < 2; r++) begin
         rst <= 1'b1;
         repeat (8) @(posedge clk);
         rst <= 1'b0;
         repeat (2) @(posedge clk);
         // ---------------------------------------------------------
         // reset values, first run and a reset in mid-run
         // ---------------------------------------------------------
         chk("pwr_rst", 8'hFF, pwr);
         chk("pwr4_rst", 8'h0F, pwr4);
         host.rd(7'h02, ok, rd8);
         chk("rvalid_rst", 25'h1, {24'h0, ok});
         chk("mask_rst", 8'h00, rd8);
         chk("mask4_rst", 8'hF0, rdata4);
         host.rd(7'h03, ok, rd8);
         chk("rvalid_feat_rst", 25'h1, {24'h0, ok});
         chk("feat_rst", 8'h00, rd8);
         $display("reset test %0d done", r);
         if (r == 1)
            break;
         // feature rows write bits 5 and 3 as zero, except the refusal row
         for (int i = 0; i < 10; i++) begin
            host.wr(rows[i].a, rows[i].d);
            host.rd(rows[i].a, ok, rd8);
            chk("rvalid", 25'h1, {24'h0, ok});
            chk("readback", rows[i].e8, rd8);
            chk("readback4", rows[i].e4, rdata4);
            if (rows[i].a == 7'h02) begin
               // braces keep the inversion at eight bits
               chk("power_on", {~rows[i].d}, pwr);
               chk("scan", {~rows[i].d}, scan);
               chk("power_on4", ~rows[i].d & 8'h0F, pwr4);
               chk("all_off", {24'h0, rows[i].d == 8'hFF}, {24'h0, all_off});
               chk("all_off4", {24'h0, rows[i].d[3:0] == 4'hF}, {24'h0, all_off4});
            end else begin
               chk("chain", rows[i].e8[7:6], chain);
               chk("alarm", rows[i].e8[4], alarm);
               chk("format", rows[i].e8[2:0], fmt);
            end
            $display("row test %0d done", i);
         end
         host.rd(7'h04, ok, rd8);
         chk("unmapped_rvalid", 25'h0, {24'h0, ok});
         chk("unmapped_data", 25'h0, rd8);
         // ---------------------------------------------------------
         // output word per format, channel 5 powered down
         // ---------------------------------------------------------
         host.wr(7'h02, 8'h20);
         for (int f = 0; f < 4; f++) begin
            host.wr(7'h03, 8'h90 | f[7:0]);
            do_conv(3'h2);
            chk("word", {16'hA5C3, 4'h2, 2'h2, 3'h3} & keep[f], word);
            chk("nbits", nb[f], nbits);
            chk("invalid", 25'h0, {24'h0, inval});
         end
         do_conv(3'h5);
         chk("invalid_off", 25'h1, {24'h0, inval});
         chk("invalid_absent", 25'h1, {24'h0, inval4});
         host.wr(7'h02, 8'hFF);
         do_conv(3'h0);
         chk("invalid_all", 25'h1, {24'h0, inval});
         $display("format test done");
      end
      finish_test();
   end
endmodule // acp_regs_test
